// ### design/tbct_pkg.sv
// Package: register map, field positions and timing constants of the timebase capture timer
package tbct_pkg;
  // Register indices; each register is one aligned word, byte address is four times the index
  localparam logic [7:0] OFF_TB2_CSR   = 8'h08;
  localparam logic [7:0] OFF_RELOAD    = 8'h09;
  localparam logic [7:0] OFF_CNT2      = 8'h0a;
  localparam logic [7:0] OFF_TB1_CSR   = 8'h0b;
  localparam logic [7:0] OFF_CAPTURE   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
  localparam logic [7:0] OFF_CTRL      = 8'h18;
  // Field positions
  localparam int TB2_FLAG_BIT  = 0;
  localparam int TB2_IE_BIT    = 1;
  localparam int TB1_FLAG_BIT  = 3;
  localparam int TB1_IE_BIT    = 4;
  localparam int PERIOD_BIT    = 5;
  localparam int CAP_FLAG_BIT  = 6;
  localparam int CAP_IE_BIT    = 7;
  localparam int EV_TB1_BIT    = 0;
  localparam int EV_TB2_BIT    = 1;
  localparam int EV_CAP_BIT    = 2;
  localparam int CTRL_GIE_BIT  = 0;
  localparam int CTRL_HALT_BIT = 1;
  // Reset values and counter limits
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] CNT1_TOP   = 8'hf9;
  localparam logic [7:0] CNT2_TOP   = 8'hff;
  localparam logic [2:0] EV_ZERO    = 3'h0;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Clock divider: counters tick at oscillator / 32
  localparam int TICK_DIV = 32;
  localparam logic [4:0] PRE_TOP = 5'h1f;
  localparam logic [1:0] APB_PSLVERR_OK = 2'h0;
endpackage : tbct_pkg

// ### design/tbct_prescale.sv
// Prescaler: one-cycle tick every TICK_DIV enabled clocks
`timescale 1ns/100ps
module tbct_prescale (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  // Control
  input  wire logic run,
  output logic      tick
);
  logic [4:0] pre_reg;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_reg <= 5'h00;
    end else if (run) begin
      pre_reg <= pre_reg + 5'h01;
    end
  end

  assign tick = run && (pre_reg == tbct_pkg::PRE_TOP);
endmodule : tbct_prescale

// ### design/tbct_edge.sv
// Capture pin synchroniser and any-edge detector
`timescale 1ns/100ps
module tbct_edge (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  input  wire logic ce,
  // Pin and event
  input  wire logic pin,
  output logic      edge_seen
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Two flops before use; first stage read only by second
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign edge_seen = ce && (sync_reg != last_reg);
endmodule : tbct_edge

// ### design/tbct_timer.sv
// Top: timebase and capture timer with APB register access
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module tbct_timer (
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Capture pin
  input  wire logic        CAPTURE_INPUT_PIN,
  // Interrupt requests
  output logic             TB1_IRQ,
  output logic             TB2_IRQ,
  output logic             CAP_IRQ,
  output logic             IRQ
);
  logic [7:0] cnt1_reg;
  logic       half_reg;
  logic [7:0] cnt2_reg;
  logic [7:0] reload_reg;
  logic [7:0] capture_reg;
  logic       tb1_ie_reg;
  logic       tb2_ie_reg;
  logic       cap_ie_reg;
  logic       period_reg;
  logic       tb1_flag_reg;
  logic       tb2_flag_reg;
  logic       cap_flag_reg;
  logic [2:0] ev_stat_reg;
  logic [2:0] ev_mask_reg;
  logic [1:0] ctrl_reg;
  logic       tick;
  logic       pin_edge;
  logic       tb1_ovf;
  logic       tb2_ovf;
  logic       cap_evt;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [2:0] events;
  logic [31:0] rdata_next;
  logic [7:0] reg_idx;

  // Word index of the access; byte lanes are not decoded
  assign reg_idx = {2'h0, PADDR[7:2]};

  // Single-cycle access: answer in the access phase
  assign acc = PSEL && PENABLE && CE;
  assign wr  = acc && PWRITE;
  assign rd  = acc && !PWRITE;

  tbct_prescale u_pre (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .run   (CE && !ctrl_reg[tbct_pkg::CTRL_HALT_BIT]),
    .tick  (tick)
  );

  tbct_edge u_edge (
    .MCLK      (MCLK),
    .RST_N     (RST_N),
    .ce        (CE),
    .pin       (CAPTURE_INPUT_PIN),
    .edge_seen (pin_edge)
  );

  assign tb1_ovf = tick && (cnt1_reg == tbct_pkg::CNT1_TOP) && (half_reg || !period_reg);
  assign tb2_ovf = tick && (cnt2_reg == tbct_pkg::CNT2_TOP);
  assign cap_evt = pin_edge && !cap_flag_reg;
  assign events  = {cap_evt, tb2_ovf, tb1_ovf};

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt1_reg <= tbct_pkg::BYTE_ZERO;
      half_reg <= 1'b0;
    end else if (tick) begin
      if (cnt1_reg == tbct_pkg::CNT1_TOP) begin
        cnt1_reg <= tbct_pkg::BYTE_ZERO;
        half_reg <= period_reg && !half_reg;
      end else begin
        cnt1_reg <= cnt1_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt2_reg <= tbct_pkg::BYTE_ZERO;
    end else if (tick) begin
      cnt2_reg <= tb2_ovf ? reload_reg : cnt2_reg + 8'h01;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      reload_reg <= tbct_pkg::BYTE_ZERO;
    end else if (wr && reg_idx == tbct_pkg::OFF_RELOAD) begin
      reload_reg <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      capture_reg <= tbct_pkg::BYTE_ZERO;
    end else if (cap_evt) begin
      capture_reg <= cnt1_reg;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tb1_ie_reg <= 1'b0;
      tb2_ie_reg <= 1'b0;
      cap_ie_reg <= 1'b0;
      period_reg <= 1'b0;
    end else if (wr && reg_idx == tbct_pkg::OFF_TB1_CSR) begin
      cap_ie_reg <= PWDATA[tbct_pkg::CAP_IE_BIT];
      period_reg <= PWDATA[tbct_pkg::PERIOD_BIT];
      tb1_ie_reg <= PWDATA[tbct_pkg::TB1_IE_BIT];
    end else if (wr && reg_idx == tbct_pkg::OFF_TB2_CSR) begin
      tb2_ie_reg <= PWDATA[tbct_pkg::TB2_IE_BIT];
    end
  end

  // flags, set wins over read clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tb1_flag_reg <= 1'b0;
      tb2_flag_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
    end else if (CE) begin
      tb1_flag_reg <= tb1_ovf || (tb1_flag_reg && !(rd && reg_idx == tbct_pkg::OFF_TB1_CSR));
      tb2_flag_reg <= tb2_ovf || (tb2_flag_reg && !(rd && reg_idx == tbct_pkg::OFF_TB2_CSR));
      cap_flag_reg <= cap_evt || (cap_flag_reg && !(rd && reg_idx == tbct_pkg::OFF_CAPTURE));
    end
  end

  // Sticky event status, write one to clear; set wins
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ev_stat_reg <= tbct_pkg::EV_ZERO;
    end else if (CE) begin
      if (wr && reg_idx == tbct_pkg::OFF_IRQ_STAT) begin
        ev_stat_reg <= events | (ev_stat_reg & ~PWDATA[2:0]);
      end else begin
        ev_stat_reg <= events | ev_stat_reg;
      end
    end
  end

  // Mask and control registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ev_mask_reg <= tbct_pkg::EV_ZERO;
      ctrl_reg    <= tbct_pkg::CTRL_RESET;
    end else if (wr && reg_idx == tbct_pkg::OFF_IRQ_MASK) begin
      ev_mask_reg <= PWDATA[2:0];
    end else if (wr && reg_idx == tbct_pkg::OFF_CTRL) begin
      ctrl_reg <= PWDATA[1:0];
    end
  end

  // Read mux; reserved bits zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_idx)
      tbct_pkg::OFF_TB2_CSR: begin
        rdata_next[tbct_pkg::TB2_IE_BIT]   = tb2_ie_reg;
        rdata_next[tbct_pkg::TB2_FLAG_BIT] = tb2_flag_reg;
      end
      tbct_pkg::OFF_RELOAD:  rdata_next[7:0] = reload_reg;
      tbct_pkg::OFF_CNT2:    rdata_next[7:0] = cnt2_reg;
      tbct_pkg::OFF_TB1_CSR: begin
        rdata_next[tbct_pkg::CAP_IE_BIT]   = cap_ie_reg;
        rdata_next[tbct_pkg::CAP_FLAG_BIT] = cap_flag_reg;
        rdata_next[tbct_pkg::PERIOD_BIT]   = period_reg;
        rdata_next[tbct_pkg::TB1_IE_BIT]   = tb1_ie_reg;
        rdata_next[tbct_pkg::TB1_FLAG_BIT] = tb1_flag_reg;
      end
      tbct_pkg::OFF_CAPTURE:  rdata_next[7:0] = capture_reg;
      tbct_pkg::OFF_IRQ_STAT: rdata_next[2:0] = ev_stat_reg;
      tbct_pkg::OFF_IRQ_MASK: rdata_next[2:0] = ev_mask_reg;
      tbct_pkg::OFF_CTRL:     rdata_next[1:0] = ctrl_reg;
      default:                rdata_next = 32'h0000_0000;
    endcase
  end

  // Registered answer: PREADY high in the first cycle of the access phase, one cycle after setup
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rdata_next : 32'h0000_0000;
    end
  end

  // per-event requests, gated by enable and global unmask
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      TB1_IRQ <= 1'b0;
      TB2_IRQ <= 1'b0;
      CAP_IRQ <= 1'b0;
      IRQ     <= 1'b0;
    end else if (CE) begin
      TB1_IRQ <= tb1_flag_reg && tb1_ie_reg && ctrl_reg[tbct_pkg::CTRL_GIE_BIT];
      TB2_IRQ <= tb2_flag_reg && tb2_ie_reg && ctrl_reg[tbct_pkg::CTRL_GIE_BIT];
      CAP_IRQ <= cap_flag_reg && cap_ie_reg && ctrl_reg[tbct_pkg::CTRL_GIE_BIT];
      IRQ     <= |(ev_stat_reg & ev_mask_reg);
    end
  end

  // Flag cleared by read unless set again
  flag_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (rd && reg_idx == tbct_pkg::OFF_TB2_CSR && !tb2_ovf) |=> !tb2_flag_reg)
    else $error("timebase2 flag not cleared by read");

  flag_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    tb2_ovf |=> tb2_flag_reg) else $error("timebase2 flag not set");

  cnt1_wrap_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (tick && cnt1_reg == tbct_pkg::CNT1_TOP) |=> cnt1_reg == tbct_pkg::BYTE_ZERO)
    else $error("counter1 did not wrap");

  reload_load_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    tb2_ovf |=> cnt2_reg == $past(reload_reg)) else $error("reload not applied");

  cap_inhibit_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    cap_flag_reg |=> $stable(capture_reg)) else $error("capture while flag set");

  sequence cap_seq;
    cap_evt ##1 cap_flag_reg;
  endsequence
  cap_latch_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    cap_evt |-> cap_seq ##0 (capture_reg == $past(cnt1_reg)))
    else $error("capture value wrong");

  halt_stop_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ctrl_reg[tbct_pkg::CTRL_HALT_BIT] |=> $stable(cnt2_reg)) else $error("count in halt");

  irq_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CE && !tb1_ie_reg) |=> !TB1_IRQ) else $error("tb1 request while disabled");

  rsvd_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (PREADY && $past(reg_idx) == tbct_pkg::OFF_TB2_CSR) |-> PRDATA[7:2] == 6'h00)
    else $error("reserved bits not zero");

  tb1_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    tb1_ovf |=> tb1_flag_reg) else $error("timebase1 flag not set");

  cap_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (rd && reg_idx == tbct_pkg::OFF_CAPTURE && !cap_evt) |=> !cap_flag_reg)
    else $error("capture flag not cleared by read");

  reload_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr && reg_idx == tbct_pkg::OFF_RELOAD) |=> reload_reg == $past(PWDATA[7:0]))
    else $error("reload write lost");

  cnt2_ro_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr && reg_idx == tbct_pkg::OFF_CNT2 && !tick) |=> $stable(cnt2_reg))
    else $error("counter2 written");

  // Global unmask gates every per-event request
  sequence unmask_off_seq;
    CE && !ctrl_reg[tbct_pkg::CTRL_GIE_BIT];
  endsequence
  sequence no_request_seq;
    !TB1_IRQ && !TB2_IRQ && !CAP_IRQ;
  endsequence
  irq_unmask_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    unmask_off_seq |=> no_request_seq) else $error("request while masked");
endmodule : tbct_timer

// ### dv/tbct_pin_model.sv
// Capture pin source model driving the capture input
`timescale 1ns/100ps
module tbct_pin_model (
  // Clock
  input  wire logic MCLK,
  // Pin
  output logic      pin
);
  initial pin = 1'b0;
  // One edge per call, launched just after a clock edge
  task flip();
    @(posedge MCLK);
    pin <= ~pin;
  endtask : flip
endmodule : tbct_pin_model

// ### dv/test_timebase_capture_timer.sv
// Testbench for the timebase and capture timer
`timescale 1ns/100ps
module test_timebase_capture_timer;
  logic        mclk, rst_n, ce, psel, penable, pwrite, pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, a;
  logic        pready, pslverr, tb1_irq, tb2_irq, cap_irq, irq;
  int          miscompares, checks_done, cyc, t;
  wire  [3:0]  irqs = {irq, cap_irq, tb2_irq, tb1_irq};

  tbct_timer tbct_timer_inst (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CAPTURE_INPUT_PIN(pin), .TB1_IRQ(tb1_irq),
    .TB2_IRQ(tb2_irq), .CAP_IRQ(cap_irq), .IRQ(irq));
  tbct_pin_model tbct_pin_model_inst (.MCLK(mclk), .pin(pin));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Register index in, word byte address out; access held until pready is high
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ad[5:0], 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for an interrupt line to reach a level
  task wt(input int s, input logic lv, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (irqs[s] !== lv && n < lim);
    if (n >= lim) begin
      miscompares++;
      print_verdict();
    end
  endtask : wt

  task t_reset();
    apb(0, 8'h08, 0); chk(q, 32'h0);
    apb(0, 8'h09, 0); chk(q, 32'h0);
    apb(0, 8'h0b, 0); chk(q, 32'h0);
    apb(0, 8'h0c, 0); chk(q, 32'h0);
    apb(0, 8'h04, 0); chk(q, 32'h0);
    apb(1, 8'h08, 32'hff);
    apb(0, 8'h08, 0); chk(q, 32'h02);
    apb(1, 8'h0a, 32'h55);
    apb(0, 8'h0a, 0); chk({31'h0, q < 32'h20}, 32'h1);
    apb(1, 8'h18, 32'h01);
  endtask : t_reset

  task t_reload();
    apb(1, 8'h09, 32'hfe);
    apb(0, 8'h09, 0); chk(q, 32'hfe);
    wt(1, 1, 9000);
    apb(0, 8'h08, 0); chk(q, 32'h03);
    apb(0, 8'h08, 0); chk(q, 32'h02);
    apb(0, 8'h0a, 0); chk({31'h0, q >= 32'hfe}, 32'h1);
    apb(1, 8'h08, 32'h00);
    apb(1, 8'h09, 32'h00);
  endtask : t_reload

  // Clear, then wait for the next timebase-1 event
  task next_tb1(input int lim);
    apb(0, 8'h0b, 0);
    wt(0, 0, 8);
    wt(0, 1, lim);
  endtask : next_tb1

  task t_tb1();
    apb(1, 8'h0b, 32'h10);
    wt(0, 1, 9000);
    apb(0, 8'h0b, 0); chk(q, 32'h18);
    apb(0, 8'h0b, 0); chk(q, 32'h10);
    wt(0, 1, 9000);
    t = cyc;
    next_tb1(9000); chk(cyc - t, 8000);
    apb(1, 8'h0b, 32'h30);
    next_tb1(17000);
    t = cyc;
    next_tb1(17000); chk(cyc - t, 16000);
  endtask : t_tb1

  task t_cap();
    apb(1, 8'h0b, 32'h90);
    // Software clears the capture flag first by reading the capture register
    apb(0, 8'h0c, 0);
    next_tb1(17000);
    next_tb1(9000);
    t = cyc;
    while (cyc < t + 3200) @(posedge mclk);
    tbct_pin_model_inst.flip();
    wt(2, 1, 10);
    apb(0, 8'h0b, 0); chk(q & 32'h40, 32'h40);
    apb(0, 8'h10, 0); chk(q & 32'h04, 32'h04);
    // Second edge while flagged must not overwrite
    tbct_pin_model_inst.flip();
    repeat (200) @(posedge mclk);
    apb(0, 8'h0c, 0); chk({31'h0, q >= 32'h63 && q <= 32'h65}, 32'h1);
    apb(0, 8'h0b, 0); chk(q & 32'h40, 32'h0);
    wt(2, 0, 8);
    apb(1, 8'h10, 32'h07);
    apb(1, 8'h14, 32'h04);
    tbct_pin_model_inst.flip();
    wt(3, 1, 20);
    apb(1, 8'h14, 32'h00);
    wt(3, 0, 8);
    apb(1, 8'h14, 32'h04);
    wt(3, 1, 8);
    apb(1, 8'h10, 32'h04);
    wt(3, 0, 8);
  endtask : t_cap

  task t_halt();
    apb(1, 8'h18, 32'h03);
    apb(0, 8'h0a, 0);
    a = q;
    repeat (100) @(posedge mclk);
    apb(0, 8'h0a, 0); chk(q, a);
    apb(1, 8'h18, 32'h01);
    repeat (100) @(posedge mclk);
    apb(0, 8'h0a, 0); chk({31'h0, q !== a}, 32'h1);
  endtask : t_halt

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    ce = 1'b1;
    miscompares = 0;
    checks_done = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_reload();
    t_tb1();
    t_cap();
    t_halt();
    print_verdict();
  end
endmodule : test_timebase_capture_timer
